/* rtl/scdc_pkg.sv */
// constants, carriers and state types of the seven channel transfer controller
package scdc_pkg;
    // channel and request counts
    localparam int NCH = 7;
    localparam int NPREQ = 16;
    localparam int NTRIG = 4;
    localparam int SEL_W = 5;
    localparam int CNT_W = 17;
    localparam int AVS_AW = 6;
    localparam int MEM_AW = 4;
    localparam int FLG_W = 3;
    localparam int STAT_W = NCH * FLG_W;
    // register word offsets, channel n sits at n * 8
    localparam logic [2:0] REG_CTRL = 3'h0;
    localparam logic [2:0] REG_COUNT = 3'h1;
    localparam logic [2:0] REG_SRC = 3'h2;
    localparam logic [2:0] REG_DST = 3'h3;
    localparam logic [2:0] REG_CSRC = 3'h4;
    localparam logic [2:0] REG_CDST = 3'h5;
    localparam logic [AVS_AW-1:0] REG_STATUS = 6'h38;
    localparam logic [AVS_AW-1:0] REG_MASK = 6'h39;
    // channel control field positions
    localparam int CTL_W = 16;
    localparam int CTL_EN_BIT = 0;
    localparam int CTL_CIRC_BIT = 1;
    localparam int CTL_M2M_BIT = 2;
    localparam int CTL_SINC_BIT = 3;
    localparam int CTL_DINC_BIT = 4;
    localparam int CTL_SSZ_LSB = 5;
    localparam int CTL_DSZ_LSB = 7;
    localparam int CTL_PRIO_LSB = 9;
    localparam int CTL_SEL_LSB = 11;
    // event flag positions inside a channel's status group
    localparam int FLG_TC = 0;
    localparam int FLG_HT = 1;
    localparam int FLG_TE = 2;
    // item sizes and bus response code
    localparam logic [1:0] SZ_BYTE = 2'h0;
    localparam logic [1:0] SZ_HALF = 2'h1;
    localparam logic [1:0] SZ_WORD = 2'h2;
    localparam logic [1:0] RESP_OK = 2'h0;
    // reset values
    localparam logic [CTL_W-1:0] CTRL_RST = 16'h0000;
    localparam logic [STAT_W-1:0] STATUS_RST = 21'h000000;
    localparam logic [STAT_W-1:0] MASK_RST = 21'h000000;

    typedef enum logic [3:0] {
        ENG_IDLE = 4'b0001,
        ENG_RD = 4'b0010,
        ENG_WR = 4'b0100,
        ENG_RELOAD = 4'b1000
    } scdc_eng_t;

    typedef enum logic [2:0] {
        BUS_IDLE = 3'b001,
        BUS_FETCH = 3'b010,
        BUS_ANS = 3'b100
    } scdc_bus_t;

    typedef struct packed {
        logic read;
        logic write;
        logic [AVS_AW-1:0] address;
        logic [31:0] writedata;
    } scdc_avs_req_t;

    typedef struct packed {
        logic [31:0] readdata;
        logic waitrequest;
    } scdc_avs_rsp_t;

    typedef struct packed {
        logic [31:0] address;
        logic read;
        logic write;
        logic [31:0] writedata;
        logic [3:0] byteenable;
    } scdc_mst_req_t;

    typedef struct packed {
        logic [31:0] readdata;
        logic waitrequest;
        logic [1:0] response;
    } scdc_mst_rsp_t;

    typedef struct packed {
        logic [NCH-1:0][CTL_W-1:0] ctrl;
        logic [NCH-1:0][CNT_W-1:0] cnt_prog;
        logic [NCH-1:0][CNT_W-1:0] cnt_rem;
        logic [NCH-1:0][31:0] cur_src;
        logic [NCH-1:0][31:0] cur_dst;
        logic [NCH-1:0] trig_pend;
        logic [NTRIG-1:0] trig_prev;
        logic [STAT_W-1:0] status;
        logic [STAT_W-1:0] mask;
        scdc_eng_t eng;
        logic [2:0] ch;
        logic [1:0] rl;
        scdc_bus_t bus;
        scdc_avs_rsp_t avs;
        scdc_mst_req_t mst;
        logic [NCH-1:0] ack;
        logic [NCH-1:0] chan_irq;
        logic irq;
    } scdc_state_t;

    typedef struct packed {
        logic [(1<<MEM_AW)-1:0][31:0] words;
        logic [31:0] rda;
        logic [31:0] rdb;
    } scdc_mem_state_t;
endpackage : scdc_pkg

/* rtl/scdc_base_mem.sv */
// programmed start address store, one write port and two registered read ports
`timescale 1ns/1ps
module scdc_base_mem import scdc_pkg::*; (
    // clock and reset
    input wire logic clock,
    input wire logic rst,
    // write port
    input wire logic we,
    input wire logic [MEM_AW-1:0] wr_addr,
    input wire logic [31:0] wr_data,
    // read ports, data one cycle after the address
    input wire logic [MEM_AW-1:0] rda_addr,
    output logic [31:0] rda_data,
    input wire logic [MEM_AW-1:0] rdb_addr,
    output logic [31:0] rdb_data
);
    scdc_mem_state_t st_ff, nxt_st;

    // next state: read first, reads see the old word
    always_comb begin
        nxt_st = st_ff;
        nxt_st.rda = st_ff.words[rda_addr];
        nxt_st.rdb = st_ff.words[rdb_addr];
        if (we) begin
            nxt_st.words[wr_addr] = wr_data;
        end
    end

    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            st_ff <= '0;
        end else begin
            st_ff <= nxt_st;
        end
    end

    assign rda_data = st_ff.rda;
    assign rdb_data = st_ff.rdb;
endmodule : scdc_base_mem

/* rtl/scdc_dma.sv */
// seven channel transfer controller with request router, arbiter and bus master
//
// Summary of operation
// - Seven channels, each with own addresses, widths, count and mode.
// - Router lets software map any peripheral request onto any channel.
// - Router also takes hardware trigger inputs that start channel items.
// - Arbiter grants by per-channel software priority, four levels.
// - Equal priority: lower-numbered channel wins.
// - Separate source/destination widths; items padded or truncated between them.
// - Circular mode restarts over the same buffer instead of stopping.
// - Half, complete and error flags per channel, ORed into one channel interrupt.
// - Memory-to-memory copies run with no request pacing.
// - Peripheral/memory directions in any combination are supported.
// - Flash, SRAM and bus peripherals all reachable as source or destination.
// - Programmable item count per channel up to 65536.
//
// Our own choices: the placing of the registers and register access over Avalon-MM.
`timescale 1ns/1ps
module scdc_dma import scdc_pkg::*; (
    // clock and reset
    input wire logic clock,
    input wire logic rst,
    // register bus slave
    input wire scdc_avs_req_t avs_req,
    output scdc_avs_rsp_t avs_rsp,
    // system bus master
    output scdc_mst_req_t mst_req,
    input wire scdc_mst_rsp_t mst_rsp,
    // request sources
    input wire logic [NPREQ-1:0] periph_req,
    input wire logic [NTRIG-1:0] trig_in,
    output logic [NCH-1:0] periph_ack,
    // interrupts
    output logic [NCH-1:0] chan_irq,
    output logic irq
);
    scdc_state_t st_ff, nxt_st;
    logic [NCH-1:0] elig;
    logic gnt_valid;
    logic [2:0] gnt_ch;
    logic [1:0] gnt_prio;
    logic mem_we;
    logic [MEM_AW-1:0] mem_wr_addr;
    logic [MEM_AW-1:0] rda_addr;
    logic [MEM_AW-1:0] rdb_addr;
    logic [31:0] rda_data;
    logic [31:0] rdb_data;
    logic [2:0] bus_ch;
    logic [2:0] bus_reg;
    logic bus_ch_ok;

    // right-align one item out of a bus word
    function automatic logic [31:0] scdc_pick(input logic [31:0] d, input logic [1:0] lane,
                                              input logic [1:0] sz);
        logic [31:0] s;
        s = d >> {lane, 3'h0};
        case (sz)
            SZ_BYTE: scdc_pick = {24'h000000, s[7:0]};
            SZ_HALF: scdc_pick = {16'h0000, s[15:0]};
            default: scdc_pick = s;
        endcase
    endfunction : scdc_pick

    // byte enables of one item on its lane
    function automatic logic [3:0] scdc_be(input logic [1:0] lane, input logic [1:0] sz);
        case (sz)
            SZ_BYTE: scdc_be = 4'h1 << lane;
            SZ_HALF: scdc_be = 4'h3 << lane;
            default: scdc_be = 4'hF;
        endcase
    endfunction : scdc_be

    // address step of one item
    function automatic logic [31:0] scdc_step(input logic [1:0] sz);
        case (sz)
            SZ_BYTE: scdc_step = 32'h00000001;
            SZ_HALF: scdc_step = 32'h00000002;
            default: scdc_step = 32'h00000004;
        endcase
    endfunction : scdc_step

    // router: each channel picks one peripheral line or one trigger
    for (genvar g = 0; g < NCH; g++) begin : g_route
        logic [SEL_W-1:0] sel;
        logic paced;
        assign sel = st_ff.ctrl[g][CTL_SEL_LSB +: SEL_W];
        assign paced = sel[SEL_W-1] ? st_ff.trig_pend[g] : periph_req[sel[SEL_W-2:0]];
        // the channel just acked sits out one cycle so a level request can drop
        assign elig[g] = st_ff.ctrl[g][CTL_EN_BIT] && (st_ff.cnt_rem[g] != '0)
                         && !st_ff.ack[g]
                         && (st_ff.ctrl[g][CTL_M2M_BIT] || paced);
    end

    // arbiter: highest level first, downward scan so lower index wins ties
    always_comb begin
        gnt_valid = 1'b0;
        gnt_ch = 3'h0;
        gnt_prio = 2'h0;
        for (int c = NCH - 1; c >= 0; c--) begin
            if (elig[c] && (!gnt_valid || st_ff.ctrl[c][CTL_PRIO_LSB +: 2] >= gnt_prio)) begin
                gnt_valid = 1'b1;
                gnt_ch = 3'(c);
                gnt_prio = st_ff.ctrl[c][CTL_PRIO_LSB +: 2];
            end
        end
    end

    // register bus decode, address is held by the master for the whole access
    assign bus_ch = avs_req.address[5:3];
    assign bus_reg = avs_req.address[2:0];
    assign bus_ch_ok = (bus_ch < 3'(NCH));
    assign rda_addr = {bus_ch, bus_reg == REG_DST};
    assign rdb_addr = {st_ff.ch, st_ff.rl != 2'h0};
    assign mem_wr_addr = {bus_ch, bus_reg == REG_DST};
    assign mem_we = (st_ff.bus == BUS_ANS) && avs_req.write && bus_ch_ok
                    && (bus_reg == REG_SRC || bus_reg == REG_DST);

    // programmed start addresses, read back on circular reload
    scdc_base_mem u_base_mem (
        .clock(clock),
        .rst(rst),
        .we(mem_we),
        .wr_addr(mem_wr_addr),
        .wr_data(avs_req.writedata),
        .rda_addr(rda_addr),
        .rda_data(rda_data),
        .rdb_addr(rdb_addr),
        .rdb_data(rdb_data)
    );

    // next state of engine, bus slave, router and flags
    always_comb begin
        logic [STAT_W-1:0] setv;
        logic [STAT_W-1:0] clrv;
        logic [31:0] item;
        logic [CNT_W-1:0] rem;
        logic [1:0] ssz;
        logic [1:0] dsz;
        logic [SEL_W-1:0] sel;
        int ci;
        nxt_st = st_ff;
        setv = '0;
        clrv = '0;
        item = '0;
        rem = '0;
        ci = int'(st_ff.ch);
        ssz = st_ff.ctrl[ci][CTL_SSZ_LSB +: 2];
        dsz = st_ff.ctrl[ci][CTL_DSZ_LSB +: 2];
        sel = '0;
        nxt_st.ack = '0;
        nxt_st.trig_prev = trig_in;

        // transfer engine: one read then one write per item
        case (st_ff.eng)
            ENG_IDLE: begin
                if (gnt_valid) begin
                    nxt_st.ch = gnt_ch;
                    nxt_st.mst.address = st_ff.cur_src[gnt_ch];
                    nxt_st.mst.byteenable = scdc_be(st_ff.cur_src[gnt_ch][1:0],
                        st_ff.ctrl[gnt_ch][CTL_SSZ_LSB +: 2]);
                    nxt_st.mst.read = 1'b1;
                    nxt_st.eng = ENG_RD;
                end
            end
            ENG_RD: begin
                if (!mst_rsp.waitrequest) begin
                    nxt_st.mst.read = 1'b0;
                    if (mst_rsp.response != RESP_OK) begin
                        setv[ci * FLG_W + FLG_TE] = 1'b1;
                        nxt_st.ctrl[ci][CTL_EN_BIT] = 1'b0;
                        nxt_st.eng = ENG_IDLE;
                    end else begin
                        // wider source truncates, narrower source zero-pads
                        item = scdc_pick(mst_rsp.readdata, st_ff.cur_src[ci][1:0], ssz);
                        item = scdc_pick(item, 2'h0, dsz);
                        nxt_st.mst.address = st_ff.cur_dst[ci];
                        nxt_st.mst.writedata = item << {st_ff.cur_dst[ci][1:0], 3'h0};
                        nxt_st.mst.byteenable = scdc_be(st_ff.cur_dst[ci][1:0], dsz);
                        nxt_st.mst.write = 1'b1;
                        nxt_st.eng = ENG_WR;
                    end
                end
            end
            ENG_WR: begin
                if (!mst_rsp.waitrequest) begin
                    nxt_st.mst.write = 1'b0;
                    nxt_st.eng = ENG_IDLE;
                    if (mst_rsp.response != RESP_OK) begin
                        setv[ci * FLG_W + FLG_TE] = 1'b1;
                        nxt_st.ctrl[ci][CTL_EN_BIT] = 1'b0;
                    end else begin
                        rem = st_ff.cnt_rem[ci] - 17'h00001;
                        nxt_st.cnt_rem[ci] = rem;
                        if (st_ff.ctrl[ci][CTL_SINC_BIT]) begin
                            nxt_st.cur_src[ci] = st_ff.cur_src[ci] + scdc_step(ssz);
                        end
                        if (st_ff.ctrl[ci][CTL_DINC_BIT]) begin
                            nxt_st.cur_dst[ci] = st_ff.cur_dst[ci] + scdc_step(dsz);
                        end
                        nxt_st.ack[ci] = 1'b1;
                        nxt_st.trig_pend[ci] = 1'b0;
                        if (rem == (st_ff.cnt_prog[ci] >> 1)) begin
                            setv[ci * FLG_W + FLG_HT] = 1'b1;
                        end
                        if (rem == '0) begin
                            setv[ci * FLG_W + FLG_TC] = 1'b1;
                            if (st_ff.ctrl[ci][CTL_CIRC_BIT]) begin
                                nxt_st.rl = 2'h0;
                                nxt_st.eng = ENG_RELOAD;
                            end else begin
                                nxt_st.ctrl[ci][CTL_EN_BIT] = 1'b0;
                            end
                        end
                    end
                end
            end
            ENG_RELOAD: begin
                // address store answers one cycle after each lookup
                nxt_st.rl = st_ff.rl + 2'h1;
                if (st_ff.rl == 2'h1) begin
                    nxt_st.cur_src[ci] = rdb_data;
                end
                if (st_ff.rl == 2'h2) begin
                    nxt_st.cur_dst[ci] = rdb_data;
                    nxt_st.cnt_rem[ci] = st_ff.cnt_prog[ci];
                    nxt_st.eng = ENG_IDLE;
                end
            end
            default: begin
                nxt_st.eng = ENG_IDLE;
            end
        endcase

        // trigger edges latch after the engine so an edge in the clearing cycle is not lost
        for (int c = 0; c < NCH; c++) begin
            sel = st_ff.ctrl[c][CTL_SEL_LSB +: SEL_W];
            if (sel[SEL_W-1] && trig_in[sel[1:0]] && !st_ff.trig_prev[sel[1:0]]) begin
                nxt_st.trig_pend[c] = 1'b1;
            end
        end

        // register slave: request seen, data fetched, answer for one cycle
        case (st_ff.bus)
            BUS_IDLE: begin
                if (avs_req.read || avs_req.write) begin
                    nxt_st.bus = BUS_FETCH;
                end
            end
            BUS_FETCH: begin
                nxt_st.avs.readdata = 32'h00000000;
                if (avs_req.address == REG_STATUS) begin
                    nxt_st.avs.readdata = 32'(st_ff.status);
                end else if (avs_req.address == REG_MASK) begin
                    nxt_st.avs.readdata = 32'(st_ff.mask);
                end else if (bus_ch_ok) begin
                    case (bus_reg)
                        REG_CTRL: nxt_st.avs.readdata = 32'(st_ff.ctrl[bus_ch]);
                        REG_COUNT: nxt_st.avs.readdata = 32'(st_ff.cnt_rem[bus_ch]);
                        REG_SRC: nxt_st.avs.readdata = rda_data;
                        REG_DST: nxt_st.avs.readdata = rda_data;
                        REG_CSRC: nxt_st.avs.readdata = st_ff.cur_src[bus_ch];
                        REG_CDST: nxt_st.avs.readdata = st_ff.cur_dst[bus_ch];
                        default: nxt_st.avs.readdata = 32'h00000000;
                    endcase
                end
                nxt_st.avs.waitrequest = 1'b0;
                nxt_st.bus = BUS_ANS;
            end
            BUS_ANS: begin
                // the write lands on the edge where waitrequest is seen low
                nxt_st.avs.waitrequest = 1'b1;
                nxt_st.bus = BUS_IDLE;
                if (avs_req.write) begin
                    if (avs_req.address == REG_STATUS) begin
                        clrv = avs_req.writedata[STAT_W-1:0];
                    end else if (avs_req.address == REG_MASK) begin
                        nxt_st.mask = avs_req.writedata[STAT_W-1:0];
                    end else if (bus_ch_ok) begin
                        case (bus_reg)
                            REG_CTRL: nxt_st.ctrl[bus_ch] = avs_req.writedata[CTL_W-1:0];
                            REG_COUNT: begin
                                nxt_st.cnt_prog[bus_ch] = avs_req.writedata[CNT_W-1:0];
                                nxt_st.cnt_rem[bus_ch] = avs_req.writedata[CNT_W-1:0];
                            end
                            REG_SRC: nxt_st.cur_src[bus_ch] = avs_req.writedata;
                            REG_DST: nxt_st.cur_dst[bus_ch] = avs_req.writedata;
                            default: begin
                            end
                        endcase
                    end
                end
            end
            default: begin
                nxt_st.bus = BUS_IDLE;
                nxt_st.avs.waitrequest = 1'b1;
            end
        endcase

        // sticky flags: a set in the clearing cycle survives
        nxt_st.status = (st_ff.status & ~clrv) | setv;
        for (int c = 0; c < NCH; c++) begin
            nxt_st.chan_irq[c] = |(nxt_st.status[c * FLG_W +: FLG_W]
                                   & nxt_st.mask[c * FLG_W +: FLG_W]);
        end
        nxt_st.irq = |nxt_st.chan_irq;
    end

    // state register
    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            st_ff <= '0;
            st_ff.ctrl <= {NCH{CTRL_RST}};
            st_ff.status <= STATUS_RST;
            st_ff.mask <= MASK_RST;
            st_ff.eng <= ENG_IDLE;
            st_ff.bus <= BUS_IDLE;
            st_ff.avs.waitrequest <= 1'b1;
        end else begin
            st_ff <= nxt_st;
        end
    end

    // outputs straight from the state register
    assign avs_rsp = st_ff.avs;
    assign mst_req = st_ff.mst;
    assign periph_ack = st_ff.ack;
    assign chan_irq = st_ff.chan_irq;
    assign irq = st_ff.irq;
endmodule : scdc_dma

/* verification/scdc_mem_model.sv */
// bus memory model with wait states and faults
`timescale 1ns/1ps
module scdc_mem_model import scdc_pkg::*; (
    // clock and reset
    input wire logic clock,
    input wire logic rst,
    // bus from the controller
    input wire scdc_mst_req_t req,
    output scdc_mst_rsp_t rsp,
    // wait state mode
    input wire logic slow
);
    logic [31:0] mem [0:63];
    logic [1:0] dly_ff;
    logic [5:0] idx;
    assign idx = req.address[7:2];
    // answer when wait count is out; bit 31 faults
    assign rsp.waitrequest = !((req.read || req.write) && dly_ff == 2'h0);
    assign rsp.response = req.address[31] ? 2'h2 : RESP_OK;
    // data inverted outside an answer
    assign rsp.readdata = rsp.waitrequest ? ~mem[idx] : mem[idx];
    // byte lanes follow byteenable
    always @(posedge clock or posedge rst) begin
        if (rst) begin
            dly_ff <= 2'h0;
        end else if (!rsp.waitrequest) begin
            dly_ff <= slow ? 2'($urandom_range(3, 1)) : 2'h0;
            for (int b = 0; b < 4; b++) begin
                if (req.write && req.byteenable[b]) begin
                    mem[idx][8*b +: 8] <= req.writedata[8*b +: 8];
                end
            end
        end else if (dly_ff != 2'h0 && (req.read || req.write)) begin
            dly_ff <= dly_ff - 2'h1;
        end
    end
endmodule : scdc_mem_model

/* verification/scdc_dma_checker.sv */
// controller port assertions
`timescale 1ns/1ps
module scdc_dma_checker import scdc_pkg::*; (
    // clock and reset
    input wire logic clock,
    input wire logic rst,
    // buses
    input wire scdc_avs_req_t avs_req,
    input wire scdc_avs_rsp_t avs_rsp,
    input wire scdc_mst_req_t mst_req,
    input wire scdc_mst_rsp_t mst_rsp,
    // requests and interrupts
    input wire logic [NPREQ-1:0] periph_req,
    input wire logic [NTRIG-1:0] trig_in,
    input wire logic [NCH-1:0] periph_ack,
    input wire logic [NCH-1:0] chan_irq,
    input wire logic irq
);
    default clocking cb @(posedge clock); endclocking
    default disable iff (rst);
    sequence s_reg_taken;
        $rose(avs_req.read || avs_req.write);
    endsequence
    sequence s_reg_answer;
        avs_rsp.waitrequest ##1 avs_rsp.waitrequest ##1 !avs_rsp.waitrequest;
    endsequence
    sequence s_item_rd_ok;
        mst_req.read && !mst_rsp.waitrequest && mst_rsp.response == RESP_OK;
    endsequence
    sequence s_item_wr_done;
        mst_req.write && !mst_rsp.waitrequest;
    endsequence
    a_reg_answer_time: assert property (s_reg_taken |-> s_reg_answer)
        else $error("late register answer");
    a_reg_wait_pulse: assert property (!avs_rsp.waitrequest |=> avs_rsp.waitrequest)
        else $error("long waitrequest low");
    a_item_read_write: assert property (s_item_rd_ok |=> mst_req.write && !mst_req.read)
        else $error("no write after read");
    a_bus_hold: assert property ((mst_req.read || mst_req.write) && mst_rsp.waitrequest
        |=> $stable(mst_req))
        else $error("request not held");
    a_rd_wr_excl: assert property (!(mst_req.read && mst_req.write))
        else $error("read with write");
    a_ack_one_pulse: assert property (s_item_wr_done ##0 mst_rsp.response == RESP_OK
        |=> $onehot(periph_ack) && !mst_req.read && !mst_req.write ##1 periph_ack == '0)
        else $error("bad ack pulse");
    a_err_no_ack: assert property (s_item_wr_done ##0 mst_rsp.response != RESP_OK
        |=> periph_ack == '0)
        else $error("error acked");
    a_err_no_write: assert property (mst_req.read && !mst_rsp.waitrequest
        && mst_rsp.response != RESP_OK |=> !mst_req.write)
        else $error("write after bad read");
    a_irq_or_chan: assert property (irq == (|chan_irq))
        else $error("irq not or of channels");
    c_item: cover property (s_item_rd_ok ##1 s_item_wr_done);
endmodule : scdc_dma_checker

bind scdc_dma scdc_dma_checker chk_i (.clock(clock), .rst(rst), .avs_req(avs_req),
    .avs_rsp(avs_rsp), .mst_req(mst_req), .mst_rsp(mst_rsp), .periph_req(periph_req),
    .trig_in(trig_in), .periph_ack(periph_ack), .chan_irq(chan_irq), .irq(irq));

/* verification/scdc_dma_bench.sv */
// transfer controller bench
`timescale 1ns/1ps
module scdc_dma_bench import scdc_pkg::*;;
    logic clock = 1'b0;
    logic rst = 1'b1;
    logic slow = 1'b0;
    scdc_avs_req_t avs_req = '0;
    scdc_avs_rsp_t avs_rsp;
    scdc_mst_req_t mst_req;
    scdc_mst_rsp_t mst_rsp;
    logic [NPREQ-1:0] periph_req = '0;
    logic [NTRIG-1:0] trig_in = '0;
    logic [NCH-1:0] periph_ack;
    logic [NCH-1:0] chan_irq;
    logic irq;
    logic [31:0] rd_q[$];
    int ack_q[$];
    int error_cnt = 0;
    int total_checks = 0;
    int cyc = 0;
    logic [31:0] src;
    logic [31:0] nxt_word;

    always #2.5 clock = ~clock;
    scdc_dma DUT (.clock(clock), .rst(rst), .avs_req(avs_req), .avs_rsp(avs_rsp),
        .mst_req(mst_req), .mst_rsp(mst_rsp), .periph_req(periph_req), .trig_in(trig_in),
        .periph_ack(periph_ack), .chan_irq(chan_irq), .irq(irq));
    scdc_mem_model mem_i (.clock(clock), .rst(rst), .req(mst_req), .rsp(mst_rsp), .slow(slow));

    task automatic chk(input logic [31:0] got, exp);
        total_checks++;
        if (got !== exp) begin
            error_cnt++;
            $display("mismatch %0t got %h exp %h", $time, got, exp);
        end
    endtask : chk

    task automatic complete_run();
        $display("checks %0d errors %0d", total_checks, error_cnt);
        if (error_cnt == 0 && total_checks > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask : complete_run

    // register access held until waitrequest low
    task automatic bus(input logic w, input logic [AVS_AW-1:0] a, input logic [31:0] d);
        avs_req <= '{read: !w, write: w, address: a, writedata: d};
        @(posedge clock);
        while (avs_rsp.waitrequest !== 1'b0) @(posedge clock);
        avs_req <= '0;
        @(posedge clock);
    endtask : bus

    task automatic rd(input logic [AVS_AW-1:0] a, input logic [31:0] exp);
        rd_q.push_back(exp);
        bus(1'b0, a, 32'h0);
    endtask : rd

    function automatic logic [AVS_AW-1:0] ra(input int ch, input logic [2:0] r);
        return AVS_AW'(ch * 8) + AVS_AW'(r);
    endfunction : ra

    function automatic logic [31:0] ctl(input logic [4:0] f, input logic [1:0] ss, ds, pr,
        input int sel);
        return 32'(f) | (32'(ss) << CTL_SSZ_LSB) | (32'(ds) << CTL_DSZ_LSB)
            | (32'(pr) << CTL_PRIO_LSB) | (32'(sel) << CTL_SEL_LSB);
    endfunction : ctl

    // control last: enable starts the channel
    task automatic prog(input int ch, input logic [31:0] s, d, n, c);
        bus(1'b1, ra(ch, REG_SRC), s);
        bus(1'b1, ra(ch, REG_DST), d);
        bus(1'b1, ra(ch, REG_COUNT), n);
        bus(1'b1, ra(ch, REG_CTRL), c);
    endtask : prog

    task automatic wait_done(input bit on_irq);
        while (on_irq ? irq !== 1'b1 : ack_q.size() != 0) @(posedge clock);
        repeat (4) @(posedge clock);
    endtask : wait_done

    // watcher: oldest note vs read data or ack
    always @(posedge clock) begin
        cyc++;
        if (cyc == 6000) begin
            error_cnt++;
            $display("mismatch %0t timeout", $time);
            complete_run();
        end
        if (avs_req.read && avs_rsp.waitrequest === 1'b0) begin
            chk(avs_rsp.readdata, rd_q.pop_front());
        end
        if (periph_ack !== '0) begin
            chk(32'(periph_ack), ack_q.size() > 0 ? 32'h1 << ack_q.pop_front() : 32'h0);
            if (periph_ack[1]) periph_req[5] <= 1'b0;
            if (periph_ack[4]) periph_req[9] <= 1'b0;
        end
    end

    initial begin
        void'($urandom(47440));
        src = $urandom();
        mem_i.mem[0] = src;
        mem_i.mem[32] = $urandom();
        mem_i.mem[33] = $urandom();
        repeat (6) @(posedge clock);
        rst <= 1'b0;
        // reset values, unmapped word, storage, top count
        rd(ra(0, REG_CTRL), 32'(CTRL_RST));
        rd(REG_STATUS, 32'(STATUS_RST));
        rd(REG_MASK, 32'(MASK_RST));
        rd(6'h3F, 32'h0);
        for (int c = 0; c < NCH; c++) bus(1'b1, ra(c, REG_SRC), 32'h100 * c + 32'h4);
        for (int c = 0; c < NCH; c++) rd(ra(c, REG_SRC), 32'h100 * c + 32'h4);
        bus(1'b1, ra(5, REG_COUNT), 32'h10000);
        rd(ra(5, REG_COUNT), 32'h10000);
        // memory copy, bytes to words, flags
        bus(1'b1, REG_MASK, 32'h40);
        repeat (4) ack_q.push_back(2);
        prog(2, 32'h0, 32'h40, 32'h4, ctl(5'h1D, SZ_BYTE, SZ_WORD, 2'h0, 0));
        wait_done(1'b1);
        chk(32'(chan_irq), 32'h4);
        for (int k = 0; k < 4; k++) chk(mem_i.mem[16 + k], {24'h0, src[8*k +: 8]});
        rd(REG_STATUS, 32'hC0);
        rd(ra(2, REG_CTRL), ctl(5'h1C, SZ_BYTE, SZ_WORD, 2'h0, 0));
        bus(1'b1, REG_STATUS, 32'h1FFFFF);
        rd(REG_STATUS, 32'h0);
        chk(32'(irq), 32'h0);
        // priority levels, ties to lower channel
        for (int p = 0; p < 4; p++) begin
            slow <= p[0];
            prog(1, 32'h20, 32'h30, 32'h1, ctl(5'h01, SZ_HALF, SZ_HALF, 2'h2, 5));
            prog(4, 32'h24, 32'h34, 32'h1, ctl(5'h01, SZ_HALF, SZ_HALF, 2'(p), 9));
            ack_q.push_back(p == 3 ? 4 : 1);
            ack_q.push_back(p == 3 ? 1 : 4);
            periph_req[5] <= 1'b1;
            periph_req[9] <= 1'b1;
            wait_done(1'b0);
        end
        // circular trigger channel, restart after two
        slow <= 1'b1;
        nxt_word = ~mem_i.mem[32];
        prog(6, 32'h80, 32'hC0, 32'h2, ctl(5'h1B, SZ_WORD, SZ_WORD, 2'h1, 17));
        for (int it = 0; it < 4; it++) begin
            if (it == 2) mem_i.mem[32] = nxt_word;
            ack_q.push_back(6);
            trig_in[1] <= 1'b1;
            @(posedge clock);
            trig_in[1] <= 1'b0;
            wait_done(1'b0);
        end
        chk(mem_i.mem[48], nxt_word);
        chk(mem_i.mem[49], mem_i.mem[33]);
        rd(ra(6, REG_CDST), 32'hC0);
        rd(ra(6, REG_COUNT), 32'h2);
        rd(ra(6, REG_CTRL), ctl(5'h1B, SZ_WORD, SZ_WORD, 2'h1, 17));
        // faulting source: error flag, stop, no count
        bus(1'b1, REG_STATUS, 32'h1FFFFF);
        bus(1'b1, REG_MASK, 32'h4);
        prog(0, 32'h80000000, 32'h100, 32'h1, ctl(5'h1D, SZ_WORD, SZ_WORD, 2'h3, 0));
        wait_done(1'b1);
        rd(REG_STATUS, 32'h4);
        rd(ra(0, REG_CTRL), ctl(5'h1C, SZ_WORD, SZ_WORD, 2'h3, 0));
        rd(ra(0, REG_COUNT), 32'h1);
        complete_run();
    end
endmodule : scdc_dma_bench
